/* File: core/pcs_pkg.sv */
// package for the program sequencing and stack block
// assumes one core clock and an active-low asynchronous chip reset
package pcs_pkg;
    localparam int PC_W = 14;                     // program counter width
    localparam int PC_LO_W = 8;                   // in-page part
    localparam int PC_HI_W = 6;                   // page part
    localparam logic [13:0] PC_RESET = 14'h0000;  // first fetch address
    localparam logic [7:0] CSP_RESET = 8'h00;     // call stack origin
    localparam logic [7:0] DSP_RESET = 8'h00;     // data stack pointer reset
    localparam logic [7:0] ONE8 = 8'h01;          // unit step for pointers
    // operation requests from the instruction decoder
    typedef enum logic [3:0] {
        PCS_OP_NONE   = 4'h0,  // hold
        PCS_OP_NEXT   = 4'h1,  // advance in page
        PCS_OP_PAGE   = 4'h2,  // page advance instruction
        PCS_OP_CALL   = 4'h3,  // subroutine call to target
        PCS_OP_INTACK = 4'h4,  // interrupt acknowledge to target
        PCS_OP_RET    = 4'h5,  // subroutine return
        PCS_OP_IRET   = 4'h6,  // interrupt return
        PCS_OP_LDCSP  = 4'h7,  // load call stack pointer from accumulator
        PCS_OP_PUSH   = 4'h8,  // data push
        PCS_OP_POP    = 4'h9,  // data pop
        PCS_OP_SWDSP  = 4'hA,  // exchange accumulator and data stack pointer
        PCS_OP_JUMP   = 4'hB   // load target into program counter
    } pcs_op_type;
    // operand address modes
    typedef enum logic [1:0] {
        PCS_AM_IMM = 2'h0,  // constant from second byte
        PCS_AM_DIR = 2'h1,  // one-byte ram address
        PCS_AM_IDX = 2'h2   // constant plus index register
    } pcs_am_type;
    // sequencer states, one-hot
    typedef enum logic [4:0] {
        PCS_ST_IDLE = 5'b00001,  // accepting operations
        PCS_ST_PSH2 = 5'b00010,  // writing second saved byte
        PCS_ST_POP1 = 5'b00100,  // reading second byte back
        PCS_ST_POP2 = 5'b01000,  // reading first byte back
        PCS_ST_DPOP = 5'b10000   // data pop read
    } pcs_state_type;
endpackage : pcs_pkg

/* File: core/pcs_core.sv */
// program counter, call stack, data stack and operand address generation
// assumes a synchronous ram with one cycle read latency and a decoder that
// issues a new op only while op_ready is high
`timescale 1ns/1ps
// Functional notes
// - 14-bit program counter resets to zero
// - sequencing advances low byte; page op advances upper
// - call or interrupt saves pc and flags, two bytes
// - interrupt ack disables interrupts, writes, increments twice
// - interrupt return pops both bytes, restores flags, enables
// - subroutine return restores pc only, pointer minus two
// - call stack pointer resets zero, loadable from accumulator
// - program counter has no software access path
// - push pre-decrements; pop reads then post-increments
// - data stack pointer resets zero; first push hits top
// - accumulator exchanges with data stack pointer
// - immediate mode uses instruction second byte
// - direct mode uses one-byte ram address
// - indexed mode adds constant and index register
module pcs_core (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcs_pkg::pcs_op_type op,
    input wire logic [13:0] target,
    input wire logic [7:0] acc,
    input wire logic [7:0] push_data,
    input wire logic carry_in,
    input wire logic zero_in,
    input wire pcs_pkg::pcs_am_type am_mode,
    input wire logic [7:0] operand_byte,
    input wire logic [7:0] index_reg,
    input wire logic [7:0] ram_rdata,
    output logic op_ready,
    output logic [13:0] program_counter,
    output logic [7:0] call_stack_pointer,
    output logic [7:0] data_stack_pointer,
    output logic int_enable,
    output logic flags_load,
    output logic carry_out,
    output logic zero_out,
    output logic [7:0] acc_load_data,
    output logic acc_load,
    output logic [7:0] ram_addr,
    output logic [7:0] ram_wdata,
    output logic ram_we,
    output logic ram_re,
    output logic [7:0] operand_addr,
    output logic [7:0] operand_imm,
    output logic operand_is_mem
);
    pcs_pkg::pcs_state_type state_r;
    logic [7:0] save_lo_r;     // second saved byte held for next cycle
    logic restore_flags_r;     // return restores flags too
    logic [7:0] hi_byte_r;     // second byte captured during return
    // declared ahead of every process that steps a pointer with it
    localparam logic [7:0] ONE = pcs_pkg::ONE8;

    assign op_ready = (state_r == pcs_pkg::PCS_ST_IDLE);

    // sequencer; ram reads answer one cycle later
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= pcs_pkg::PCS_ST_IDLE;
        end else begin
            case (state_r)
                pcs_pkg::PCS_ST_IDLE: begin
                    case (op)
                        pcs_pkg::PCS_OP_CALL,
                        pcs_pkg::PCS_OP_INTACK:
                            state_r <= pcs_pkg::PCS_ST_PSH2;
                        pcs_pkg::PCS_OP_RET,
                        pcs_pkg::PCS_OP_IRET:
                            state_r <= pcs_pkg::PCS_ST_POP1;
                        pcs_pkg::PCS_OP_POP:
                            state_r <= pcs_pkg::PCS_ST_DPOP;
                        default: state_r <= pcs_pkg::PCS_ST_IDLE;
                    endcase
                end
                pcs_pkg::PCS_ST_POP1: state_r <= pcs_pkg::PCS_ST_POP2;
                default: state_r <= pcs_pkg::PCS_ST_IDLE;
            endcase
        end
    end

    // program counter; no software read or write path exists
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            program_counter <= pcs_pkg::PC_RESET;
        end else if (state_r == pcs_pkg::PCS_ST_IDLE) begin
            case (op)
                pcs_pkg::PCS_OP_NEXT:
                    program_counter[7:0] <= program_counter[7:0] + ONE;
                pcs_pkg::PCS_OP_PAGE: begin
                    program_counter[13:8] <= program_counter[13:8]
                        + 6'h01;
                    program_counter[7:0] <= 8'h00;
                end
                pcs_pkg::PCS_OP_CALL,
                pcs_pkg::PCS_OP_INTACK,
                pcs_pkg::PCS_OP_JUMP:
                    program_counter <= target;
                default: program_counter <= program_counter;
            endcase
        end else if (state_r == pcs_pkg::PCS_ST_POP2) begin
            // first byte arrives now: flags and pc bits 13:8
            program_counter <= {ram_rdata[5:0], hi_byte_r};
        end
    end

    // second saved byte, low pc bits
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            save_lo_r <= 8'h00;
            hi_byte_r <= 8'h00;
            restore_flags_r <= 1'b0;
        end else begin
            if (state_r == pcs_pkg::PCS_ST_IDLE) begin
                save_lo_r <= program_counter[7:0] + ONE;
                restore_flags_r <= (op == pcs_pkg::PCS_OP_IRET);
            end
            if (state_r == pcs_pkg::PCS_ST_POP1) begin
                hi_byte_r <= ram_rdata;
            end
        end
    end

    // call stack pointer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            call_stack_pointer <= pcs_pkg::CSP_RESET;
        end else begin
            case (state_r)
                pcs_pkg::PCS_ST_IDLE: begin
                    case (op)
                        pcs_pkg::PCS_OP_LDCSP:
                            call_stack_pointer <= acc;
                        pcs_pkg::PCS_OP_CALL,
                        pcs_pkg::PCS_OP_INTACK:
                            call_stack_pointer <= call_stack_pointer
                                + ONE;
                        pcs_pkg::PCS_OP_RET,
                        pcs_pkg::PCS_OP_IRET:
                            call_stack_pointer <= call_stack_pointer
                                - ONE;
                        default: call_stack_pointer <= call_stack_pointer;
                    endcase
                end
                pcs_pkg::PCS_ST_PSH2:
                    call_stack_pointer <= call_stack_pointer + ONE;
                pcs_pkg::PCS_ST_POP1:
                    call_stack_pointer <= call_stack_pointer - ONE;
                default: call_stack_pointer <= call_stack_pointer;
            endcase
        end
    end

    // data stack pointer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_stack_pointer <= pcs_pkg::DSP_RESET;
        end else if (state_r == pcs_pkg::PCS_ST_IDLE) begin
            if (op == pcs_pkg::PCS_OP_PUSH) begin
                data_stack_pointer <= data_stack_pointer - ONE;
            end else if (op == pcs_pkg::PCS_OP_SWDSP) begin
                data_stack_pointer <= acc;
            end
        end else if (state_r == pcs_pkg::PCS_ST_DPOP) begin
            data_stack_pointer <= data_stack_pointer + ONE;
        end
    end

    // interrupt enable; cleared on acknowledge, set after interrupt return
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_enable <= 1'b0;
        end else if (state_r == pcs_pkg::PCS_ST_IDLE
                     && op == pcs_pkg::PCS_OP_INTACK) begin
            int_enable <= 1'b0;
        end else if (state_r == pcs_pkg::PCS_ST_POP2 && restore_flags_r) begin
            int_enable <= 1'b1;
        end
    end

    // flag and accumulator results, registered outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_load <= 1'b0;
            carry_out <= 1'b0;
            zero_out <= 1'b0;
            acc_load <= 1'b0;
            acc_load_data <= 8'h00;
        end else begin
            // only interrupt return hands flags back
            flags_load <= (state_r == pcs_pkg::PCS_ST_POP2)
                && restore_flags_r;
            // flag values hold between returns, so a plain return
            // never disturbs what the alu sees
            if (state_r == pcs_pkg::PCS_ST_POP2 && restore_flags_r) begin
                carry_out <= ram_rdata[7];
                zero_out <= ram_rdata[6];
            end
            acc_load <= (state_r == pcs_pkg::PCS_ST_DPOP)
                || (state_r == pcs_pkg::PCS_ST_IDLE
                    && op == pcs_pkg::PCS_OP_SWDSP);
            // data holds after the pulse until the next load
            if (state_r == pcs_pkg::PCS_ST_DPOP) begin
                acc_load_data <= ram_rdata;
            end else if (state_r == pcs_pkg::PCS_ST_IDLE
                         && op == pcs_pkg::PCS_OP_SWDSP) begin
                acc_load_data <= data_stack_pointer;
            end
        end
    end

    // ram port, combinational from state and op
    always_comb begin
        ram_addr = 8'h00;
        ram_wdata = 8'h00;
        ram_we = 1'b0;
        ram_re = 1'b0;
        case (state_r)
            pcs_pkg::PCS_ST_IDLE: begin
                case (op)
                    pcs_pkg::PCS_OP_CALL,
                    pcs_pkg::PCS_OP_INTACK: begin
                        // first byte: flags and page bits
                        ram_addr = call_stack_pointer;
                        ram_wdata = {carry_in, zero_in,
                                     program_counter[13:8]};
                        ram_we = 1'b1;
                    end
                    pcs_pkg::PCS_OP_RET,
                    pcs_pkg::PCS_OP_IRET: begin
                        ram_addr = call_stack_pointer - ONE;
                        ram_re = 1'b1;
                    end
                    pcs_pkg::PCS_OP_PUSH: begin
                        ram_addr = data_stack_pointer - ONE;
                        ram_wdata = push_data;
                        ram_we = 1'b1;
                    end
                    pcs_pkg::PCS_OP_POP: begin
                        ram_addr = data_stack_pointer;
                        ram_re = 1'b1;
                    end
                    default: ram_addr = 8'h00;
                endcase
            end
            pcs_pkg::PCS_ST_PSH2: begin
                ram_addr = call_stack_pointer;
                ram_wdata = save_lo_r;
                ram_we = 1'b1;
            end
            pcs_pkg::PCS_ST_POP1: begin
                ram_addr = call_stack_pointer - ONE;
                ram_re = 1'b1;
            end
            default: ram_addr = 8'h00;
        endcase
    end

    // operand address generation
    always_comb begin
        operand_imm = operand_byte;
        case (am_mode)
            pcs_pkg::PCS_AM_DIR: begin
                operand_addr = operand_byte;
                operand_is_mem = 1'b1;
            end
            pcs_pkg::PCS_AM_IDX: begin
                operand_addr = operand_byte + index_reg;
                operand_is_mem = 1'b1;
            end
            default: begin
                operand_addr = 8'h00;
                operand_is_mem = 1'b0;
            end
        endcase
    end
endmodule : pcs_core

/* File: tb/pcs_core_assertions.sv */
// timing checks on the sequencing and stack block ports
// assumes ops are issued only while op_ready is high
`timescale 1ns/1ps
module pcs_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire pcs_pkg::pcs_op_type op,
    input wire logic op_ready,
    input wire logic carry_in,
    input wire logic zero_in,
    input wire logic [7:0] acc,
    input wire logic [7:0] push_data,
    input wire logic [7:0] ram_rdata,
    input wire pcs_pkg::pcs_am_type am_mode,
    input wire logic [7:0] operand_byte,
    input wire logic [7:0] index_reg,
    input wire logic [13:0] program_counter,
    input wire logic [7:0] call_stack_pointer,
    input wire logic [7:0] data_stack_pointer,
    input wire logic int_enable,
    input wire logic flags_load,
    input wire logic acc_load,
    input wire logic [7:0] acc_load_data,
    input wire logic [7:0] ram_addr,
    input wire logic [7:0] ram_wdata,
    input wire logic ram_we,
    input wire logic ram_re,
    input wire logic [7:0] operand_addr,
    input wire logic [7:0] operand_imm,
    input wire logic operand_is_mem
);
    // short aliases keep the properties readable
    wire [13:0] pc = program_counter;
    wire [7:0] csp = call_stack_pointer;
    wire [7:0] dsp = data_stack_pointer;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // low byte wraps inside the page, page part untouched
    a_next_in_page: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_NEXT |=>
        pc == {$past(pc[13:8]), $past(pc[7:0]) + 8'h01}) else $error("next");
    a_page_advance: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_PAGE |=>
        pc == {$past(pc[13:8]) + 6'h01, 8'h00}) else $error("page");
    // both frame bytes, in order, then pointer up by two
    a_save_frame: assert property (op_ready && (op ==
        pcs_pkg::PCS_OP_INTACK || op == pcs_pkg::PCS_OP_CALL) |->
        ram_we && ram_addr == csp &&
        ram_wdata == {carry_in, zero_in, pc[13:8]} ##1
        ram_we && ram_addr == $past(csp) + 8'h01 &&
        ram_wdata == $past(pc[7:0]) + 8'h01 ##1
        csp == $past(csp, 2) + 8'h02) else $error("frame");
    a_intack_mask: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_INTACK |=> !int_enable [*2]) else $error("mask");
    // second byte read first, flags and enable back after three cycles
    a_intret_restore: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_IRET |->
        ram_re && ram_addr == csp - 8'h01 ##1
        ram_re && ram_addr == $past(csp) - 8'h02 ##2
        flags_load && int_enable && csp == $past(csp, 3) - 8'h02)
        else $error("intret");
    a_ret_pc_only: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_RET |=>
        (!flags_load && $stable(int_enable)) [*3] ##0
        csp == $past(csp, 3) - 8'h02) else $error("ret");
    a_csp_load: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_LDCSP |=> csp == $past(acc)) else $error("csp");
    a_push_predec: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_PUSH |-> ram_we && ram_addr == dsp - 8'h01 &&
        ram_wdata == push_data ##1 dsp == $past(dsp) - 8'h01)
        else $error("push");
    a_pop_postinc: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_POP |-> ram_re && ram_addr == dsp ##2
        dsp == $past(dsp, 2) + 8'h01 &&
        acc_load && acc_load_data == $past(ram_rdata)) else $error("pop");
    a_dsp_swap: assert property (op_ready &&
        op == pcs_pkg::PCS_OP_SWDSP |=> dsp == $past(acc) && acc_load &&
        acc_load_data == $past(dsp)) else $error("swap");
    a_mode_imm: assert property (am_mode == pcs_pkg::PCS_AM_IMM |->
        !operand_is_mem && operand_imm == operand_byte) else $error("imm");
    a_mode_dir: assert property (am_mode == pcs_pkg::PCS_AM_DIR |->
        operand_is_mem && operand_addr == operand_byte) else $error("dir");
    a_mode_idx: assert property (am_mode == pcs_pkg::PCS_AM_IDX |->
        operand_is_mem && operand_addr == operand_byte + index_reg)
        else $error("idx");
    c_intret: cover property (op_ready && op == pcs_pkg::PCS_OP_IRET);
    c_push: cover property (op_ready && op == pcs_pkg::PCS_OP_PUSH);
    c_intack: cover property (op_ready && op == pcs_pkg::PCS_OP_INTACK);
endmodule : pcs_chk
bind pcs_core pcs_chk pcs_chk_inst (.*);

/* File: tb/cpu_pc_stack_addressing_tb.sv */
// self-checking bench for pcs_core with a one-cycle data ram model
// assumes inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module cpu_pc_stack_addressing_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    pcs_pkg::pcs_op_type op = pcs_pkg::PCS_OP_NONE;
    pcs_pkg::pcs_am_type am_mode = pcs_pkg::PCS_AM_IMM;
    logic [13:0] target = 14'h0000;
    logic [7:0] acc = 8'h00, push_data = 8'h00, operand_byte = 8'h00;
    logic [7:0] index_reg = 8'h00, ram_rdata = 8'h00;
    logic carry_in = 1'b0, zero_in = 1'b0;
    logic op_ready, int_enable, flags_load, carry_out, zero_out, acc_load;
    logic ram_we, ram_re, operand_is_mem;
    logic [13:0] program_counter;
    logic [7:0] call_stack_pointer, data_stack_pointer, acc_load_data;
    logic [7:0] ram_addr, ram_wdata, operand_addr, operand_imm;
    logic [7:0] mem [0:255];  // data ram contents
    int miscompares = 0, cmp_count = 0, cycles = 0;
    pcs_core pcs_core_inst (.*);
    always #5 clk = ~clk;
    // ram: idle read bus flips so stale data never looks valid
    always @(posedge clk) begin
        if (ram_we) mem[ram_addr] <= ram_wdata;
        ram_rdata <= ram_re ? mem[ram_addr] : ~ram_rdata;
    end
    // hang guard, far above the fifty or so cycles needed
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one op, then wait for ready and one settle edge
    task automatic issue(input pcs_pkg::pcs_op_type o);
        int n = 0;
        op = o;
        @(posedge clk);
        #1 op = pcs_pkg::PCS_OP_NONE;
        while (op_ready !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1;
    endtask : issue
    task automatic t_seq();
        issue(pcs_pkg::PCS_OP_NEXT);
        issue(pcs_pkg::PCS_OP_NEXT);
        chk(program_counter, 14'h0002);
        target = 14'h12FF;
        issue(pcs_pkg::PCS_OP_JUMP);
        issue(pcs_pkg::PCS_OP_NEXT);
        chk(program_counter, 14'h1200);
        issue(pcs_pkg::PCS_OP_PAGE);
        chk(program_counter, 14'h1300);
    endtask : t_seq
    // interrupt, nested call, plain return, interrupt return
    task automatic t_calls();
        carry_in = 1'b1;
        target = 14'h0040;
        issue(pcs_pkg::PCS_OP_INTACK);
        chk({mem[0], mem[1]}, 16'h9301);
        chk({int_enable, call_stack_pointer}, 16'h0002);
        chk(program_counter, 14'h0040);
        carry_in = 1'b0;
        zero_in = 1'b1;
        target = 14'h0100;
        issue(pcs_pkg::PCS_OP_CALL);
        chk({mem[2], mem[3]}, 16'h4041);
        issue(pcs_pkg::PCS_OP_RET);
        chk(program_counter, 14'h0041);
        chk({carry_out, zero_out, call_stack_pointer}, 16'h0002);
        issue(pcs_pkg::PCS_OP_IRET);
        chk(program_counter, 14'h1301);
        chk({int_enable, carry_out, zero_out}, 16'h0006);
        chk(call_stack_pointer, 8'h00);
        acc = 8'h20;
        issue(pcs_pkg::PCS_OP_LDCSP);
        chk(call_stack_pointer, 8'h20);
        issue(pcs_pkg::PCS_OP_INTACK);
        chk({int_enable, call_stack_pointer}, 16'h0022);
    endtask : t_calls
    // first push wraps to the top of ram
    task automatic t_dstack();
        push_data = 8'hA5;
        issue(pcs_pkg::PCS_OP_PUSH);
        chk(mem[255], 8'hA5);
        chk(data_stack_pointer, 8'hFF);
        push_data = 8'h3C;
        issue(pcs_pkg::PCS_OP_PUSH);
        issue(pcs_pkg::PCS_OP_POP);
        chk({acc_load_data, data_stack_pointer}, 16'h3CFF);
        acc = 8'h24;
        issue(pcs_pkg::PCS_OP_SWDSP);
        chk({acc_load_data, data_stack_pointer}, 16'hFF24);
    endtask : t_dstack
    // index sum wraps within the byte
    task automatic t_modes();
        operand_byte = 8'hF0;
        index_reg = 8'h20;
        am_mode = pcs_pkg::PCS_AM_IDX;
        #1 chk({operand_is_mem, operand_addr}, 9'h110);
        @(posedge clk);
        #1 am_mode = pcs_pkg::PCS_AM_DIR;
        #1 chk({operand_is_mem, operand_addr}, 9'h1F0);
        @(posedge clk);
        #1 am_mode = pcs_pkg::PCS_AM_IMM;
        #1 chk({operand_is_mem, operand_imm}, 9'h0F0);
    endtask : t_modes
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        chk(program_counter, 14'h0000);
        chk(call_stack_pointer, 8'h00);
        chk(data_stack_pointer, 8'h00);
        t_seq();
        t_calls();
        t_dstack();
        t_modes();
        final_report();
    end
endmodule : cpu_pc_stack_addressing_tb
